/* smh_host.sv */
// Bus host controller that runs word and block transactions against the gauge.
// Functional notes
// - Every transaction opens with a start.
// - Seven-bit address then direction bit sent.
// - Every transaction closes with a stop.
// - Bytes travel most significant bit first.
// - Lines only pulled low or released.
// - Last byte supplier appends packet code.
// - Receiver recomputes code and compares.
// - Host code follows last written byte.
// - Host acks last data, nacks code.
// - Code is CRC-8, polynomial x8+x2+x+1.
// - Code covers all bytes, no conditions.
// - Read order: addr-w, command, addr-r, data.
`timescale 1ns/1ps
`default_nettype none
`include "smh_map.svh"
module smh_host #(
  parameter int QUARTER = `SMH_QUARTER_CYC,
  parameter int QW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire smh_pkg::smh_kind_t cmd_kind,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_pec_en,
  output logic busy,
  output logic done,
  output logic nack_err,
  output logic pec_err,
  output logic [15:0] rdata,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic bus_clock_pin_i,
  output logic bus_clock_pin_o,
  output logic bus_clock_pin_oe,
  input wire logic bus_data_pin_i,
  output logic bus_data_pin_o,
  output logic bus_data_pin_oe
);
  import smh_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic scl_m, scl_s, sda_m, sda_s;

  // Two flops per line before any logic looks at the bus.
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= bus_clock_pin_i;
      scl_s <= scl_m;
      sda_m <= bus_data_pin_i;
      sda_s <= sda_m;
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Byte to send at a given position; positions past the fourth give the packet code.
  function automatic logic [7:0] tx_byte(input smh_kind_t k, input logic [5:0] i,
                                         input logic [6:0] a, input logic [7:0] c,
                                         input logic [15:0] w, input logic [7:0] code);
    if (i == `SMH_IDX_ADDR_W) begin
      tx_byte = {a, 1'b0};
    end else if (i == `SMH_IDX_CODE) begin
      tx_byte = c;
    end else if (i == `SMH_IDX_THIRD) begin
      tx_byte = (k == SMH_WRITE_WORD) ? w[7:0] : {a, 1'b1};
    end else if (i == `SMH_IDX_FOURTH) begin
      tx_byte = w[15:8];
    end else begin
      tx_byte = code;
    end
  endfunction

  // ==========================================================================
  // Transaction engine
  // ==========================================================================
  smh_state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [QW-1:0] qcnt, next_qcnt;
  logic [3:0] bitn, next_bitn;
  logic [5:0] idx, next_idx;
  logic [7:0] shreg, next_shreg;
  logic is_tx, next_is_tx;
  logic cnt_phase, next_cnt_phase;
  logic [5:0] rx_left, next_rx_left;
  smh_kind_t kind, next_kind;
  logic [6:0] addr, next_addr;
  logic [7:0] code, next_code;
  logic [15:0] wdata, next_wdata;
  logic pec_en, next_pec_en;
  logic next_cmd_ready, next_busy, next_done, next_nack_err, next_pec_err;
  logic [15:0] next_rdata;
  logic next_rx_valid;
  logic [7:0] next_rx_byte;
  logic next_scl_oe, next_sda_oe;
  logic crc_clr, crc_feed;
  logic [7:0] crc_din, crc;
  logic [7:0] nb, ld;
  logic tick, hold, rx_pec, more;
  logic [5:0] cnt_left;

  smh_crc8 u_crc (
    .clk(clk),
    .rst(rst),
    .clr(crc_clr),
    .feed(crc_feed),
    .din(crc_din),
    .crc(crc)
  );

  // Computes every next value of the bus engine.
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_qcnt = qcnt;
    next_bitn = bitn;
    next_idx = idx;
    next_shreg = shreg;
    next_is_tx = is_tx;
    next_cnt_phase = cnt_phase;
    next_rx_left = rx_left;
    next_kind = kind;
    next_addr = addr;
    next_code = code;
    next_wdata = wdata;
    next_pec_en = pec_en;
    next_cmd_ready = cmd_ready;
    next_busy = busy;
    next_done = 1'b0;
    next_nack_err = nack_err;
    next_pec_err = pec_err;
    next_rdata = rdata;
    next_rx_valid = 1'b0;
    next_rx_byte = rx_byte;
    next_scl_oe = bus_clock_pin_oe;
    next_sda_oe = bus_data_pin_oe;
    crc_clr = 1'b0;
    crc_feed = 1'b0;
    crc_din = 8'h00;
    nb = {shreg[6:0], sda_s};
    rx_pec = pec_en && !cnt_phase && (rx_left == 6'h01);
    cnt_left = nb[5:0] + {5'h00, pec_en};
    more = 1'b0;
    ld = tx_byte(kind, next_idx, addr, code, wdata, crc);
    tick = (qcnt == QW'(QUARTER - 1));
    // A released clock held low by the far side stretches the phase.
    hold = !bus_clock_pin_oe && !scl_s;
    if (state == SMH_ST_IDLE) begin
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      next_cmd_ready = 1'b1;
      if (cmd_valid && cmd_ready && scl_s && sda_s) begin
        next_kind = cmd_kind;
        next_addr = cmd_addr;
        next_code = cmd_code;
        next_wdata = cmd_wdata;
        next_pec_en = cmd_pec_en;
        next_cmd_ready = 1'b0;
        next_busy = 1'b1;
        next_nack_err = 1'b0;
        next_pec_err = 1'b0;
        next_idx = `SMH_IDX_ADDR_W;
        next_cnt_phase = 1'b0;
        crc_clr = 1'b1;
        next_state = SMH_ST_START;
        next_phase = 2'h0;
        next_qcnt = '0;
      end
    end else if (hold) begin
      next_qcnt = '0;
    end else if (!tick) begin
      next_qcnt = qcnt + QW'(1);
    end else begin
      next_qcnt = '0;
      next_phase = phase + 2'h1;
      case (state)
        SMH_ST_START: begin
          // Both lines high, then data falls while the clock stays high.
          case (phase)
            2'h0: next_scl_oe = 1'b0;
            2'h1: next_sda_oe = 1'b1;
            2'h2: next_scl_oe = 1'b1;
            default: begin
              next_state = SMH_ST_BYTE;
              next_bitn = 4'h0;
              next_is_tx = 1'b1;
              next_shreg = ld;
              next_sda_oe = !ld[7];
              crc_feed = 1'b1;
              crc_din = ld;
            end
          endcase
        end
        SMH_ST_BYTE: begin
          if (phase == 2'h1) begin
            next_scl_oe = 1'b0;
          end else if (phase == 2'h3) begin
            next_scl_oe = 1'b1;
            next_bitn = bitn + 4'h1;
            if (bitn < `SMH_BIT_LAST_DATA) begin
              next_shreg = nb;
              next_sda_oe = is_tx ? !shreg[6] : 1'b0;
            end else if (bitn == `SMH_BIT_LAST_DATA) begin
              next_shreg = nb;
              next_sda_oe = 1'b0;
              if (!is_tx) begin
                if (rx_pec) begin
                  next_pec_err = (nb != crc);
                  next_rx_left = 6'h00;
                end else begin
                  crc_feed = 1'b1;
                  crc_din = nb;
                  if (cnt_phase) begin
                    next_cnt_phase = 1'b0;
                    next_rx_left = cnt_left;
                  end else begin
                    next_rx_left = rx_left - 6'h01;
                    if (kind == SMH_READ_WORD) begin
                      next_rdata = {nb, rdata[15:8]};
                    end else begin
                      next_rx_valid = 1'b1;
                      next_rx_byte = nb;
                    end
                  end
                end
                // Ack while more bytes follow, nack the final one.
                more = cnt_phase ? (cnt_left != 6'h00) : (!rx_pec && rx_left > 6'h01);
                next_sda_oe = more;
              end
            end else begin
              next_sda_oe = 1'b0;
              next_idx = idx + 6'h01;
              ld = tx_byte(kind, idx + 6'h01, addr, code, wdata, crc);
              if (is_tx && sda_s) begin
                next_nack_err = 1'b1;
                next_state = SMH_ST_STOP;
                next_sda_oe = 1'b1;
              end else if (kind == SMH_WRITE_WORD) begin
                if (idx < `SMH_IDX_FOURTH || (idx == `SMH_IDX_FOURTH && pec_en)) begin
                  next_bitn = 4'h0;
                  next_shreg = ld;
                  next_sda_oe = !ld[7];
                  if (idx < `SMH_IDX_FOURTH) begin
                    crc_feed = 1'b1;
                    crc_din = ld;
                  end
                end else begin
                  next_state = SMH_ST_STOP;
                  next_sda_oe = 1'b1;
                end
              end else if (idx == `SMH_IDX_ADDR_W) begin
                next_bitn = 4'h0;
                next_shreg = ld;
                next_sda_oe = !ld[7];
                crc_feed = 1'b1;
                crc_din = ld;
              end else if (idx == `SMH_IDX_CODE) begin
                next_state = SMH_ST_START;
              end else if (idx == `SMH_IDX_THIRD) begin
                next_bitn = 4'h0;
                next_is_tx = 1'b0;
                next_cnt_phase = (kind == SMH_BLOCK_READ);
                next_rx_left = `SMH_WORD_BYTES + {5'h00, pec_en};
              end else if (rx_left == 6'h00) begin
                next_state = SMH_ST_STOP;
                next_sda_oe = 1'b1;
              end else begin
                next_bitn = 4'h0;
              end
            end
          end
        end
        SMH_ST_STOP: begin
          // Clock rises first, then data rises while the clock is high.
          case (phase)
            2'h0: next_scl_oe = 1'b0;
            2'h1: next_sda_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            default: begin
              next_state = SMH_ST_IDLE;
              next_busy = 1'b0;
              next_done = 1'b1;
            end
          endcase
        end
        default: next_state = SMH_ST_IDLE;
      endcase
    end
  end

  // Registers the bus engine.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SMH_ST_IDLE;
      phase <= 2'h0;
      qcnt <= '0;
      bitn <= 4'h0;
      idx <= 6'h00;
      shreg <= 8'h00;
      is_tx <= 1'b1;
      cnt_phase <= 1'b0;
      rx_left <= 6'h00;
      kind <= SMH_READ_WORD;
      addr <= 7'h00;
      code <= 8'h00;
      wdata <= 16'h0000;
      pec_en <= 1'b0;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
      pec_err <= 1'b0;
      rdata <= 16'h0000;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      bus_clock_pin_oe <= 1'b0;
      bus_data_pin_oe <= 1'b0;
      bus_clock_pin_o <= 1'b0;
      bus_data_pin_o <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      qcnt <= next_qcnt;
      bitn <= next_bitn;
      idx <= next_idx;
      shreg <= next_shreg;
      is_tx <= next_is_tx;
      cnt_phase <= next_cnt_phase;
      rx_left <= next_rx_left;
      kind <= next_kind;
      addr <= next_addr;
      code <= next_code;
      wdata <= next_wdata;
      pec_en <= next_pec_en;
      cmd_ready <= next_cmd_ready;
      busy <= next_busy;
      done <= next_done;
      nack_err <= next_nack_err;
      pec_err <= next_pec_err;
      rdata <= next_rdata;
      rx_valid <= next_rx_valid;
      rx_byte <= next_rx_byte;
      bus_clock_pin_oe <= next_scl_oe;
      bus_data_pin_oe <= next_sda_oe;
      bus_clock_pin_o <= 1'b0; // Lines are only ever pulled low
      bus_data_pin_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* smh_map.svh */
// Constant map for the two-wire management bus host controller.
`ifndef SMH_MAP_SVH
`define SMH_MAP_SVH
// System clock period and bus clock period, in nanoseconds.
`define SMH_CLK_PERIOD_NS 5
`define SMH_BUS_PERIOD_NS 10000
// Quarter bit time in system clocks, rounded down so the bus never runs slow of spec.
`define SMH_QUARTER_CYC (`SMH_BUS_PERIOD_NS / (`SMH_CLK_PERIOD_NS * 4))
// Packet error code generator polynomial x^8 + x^2 + x + 1, leading term dropped.
`define SMH_CRC_POLY 8'h07
`define SMH_CRC_INIT 8'h00
// Bus addresses used by the gauge and its partners.
`define SMH_ADDR_GAUGE 7'h0B
`define SMH_ADDR_CHARGER 7'h09
`define SMH_ADDR_HOST 7'h08
// Byte positions within one transaction.
`define SMH_IDX_ADDR_W 6'h00
`define SMH_IDX_CODE 6'h01
`define SMH_IDX_THIRD 6'h02
`define SMH_IDX_FOURTH 6'h03
`define SMH_IDX_FIFTH 6'h04
// Bit positions of the last data bit and of the acknowledge slot within a byte frame.
`define SMH_BIT_LAST_DATA 4'h7
`define SMH_BIT_ACK 4'h8
// Number of data bytes in a word.
`define SMH_WORD_BYTES 6'h02
`endif

/* smh_pkg.sv */
// Types shared by the bus host controller modules.
package smh_pkg;
  typedef enum logic [1:0] {
    SMH_READ_WORD,
    SMH_WRITE_WORD,
    SMH_BLOCK_READ
  } smh_kind_t;
  typedef enum logic [2:0] {
    SMH_ST_IDLE,
    SMH_ST_START,
    SMH_ST_BYTE,
    SMH_ST_STOP
  } smh_state_t;
endpackage

/* smh_crc8.sv */
// Bytewise packet error code accumulator.
`timescale 1ns/1ps
`default_nettype none
`include "smh_map.svh"
module smh_crc8 (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic feed,
  input wire logic [7:0] din,
  output logic [7:0] crc
);
  import smh_pkg::*;
  logic [7:0] next_crc;
  logic [7:0] acc;

  // Folds one byte in, most significant bit first; clear has priority.
  always_comb begin
    acc = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      acc = acc[7] ? ((acc << 1) ^ `SMH_CRC_POLY) : (acc << 1);
    end
    if (clr) begin
      next_crc = `SMH_CRC_INIT;
    end else if (feed) begin
      next_crc = acc;
    end else begin
      next_crc = crc;
    end
  end

  // Registers the running code.
  always_ff @(posedge clk) begin
    if (rst) begin
      crc <= `SMH_CRC_INIT;
    end else begin
      crc <= next_crc;
    end
  end
endmodule
`default_nettype wire

/* smh_host_asserts.sv */
// Concurrent checks on the bus host controller ports.
`timescale 1ns/1ps
`default_nettype none
module smh_host_asserts #(
  parameter int QUARTER = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic busy,
  input wire logic done,
  input wire logic nack_err,
  input wire logic pec_err,
  input wire logic rx_valid,
  input wire logic bus_clock_pin_i,
  input wire logic bus_clock_pin_o,
  input wire logic bus_clock_pin_oe,
  input wire logic bus_data_pin_i,
  input wire logic bus_data_pin_o,
  input wire logic bus_data_pin_oe
);
  import smh_pkg::*;
  localparam int LIM = 4 * QUARTER + 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ========================================
  // Sequences and properties
  sequence s_idle;
    (bus_clock_pin_i && bus_data_pin_i) [*4];
  endsequence
  sequence s_take;
    s_idle ##0 (cmd_valid && cmd_ready);
  endsequence
  property p_clk_od;
    bus_clock_pin_o == 1'b0;
  endproperty
  property p_dat_od;
    bus_data_pin_o == 1'b0;
  endproperty
  property p_take;
    s_take |=> busy && !cmd_ready;
  endproperty
  property p_start;
    $rose(busy) |-> ##[1:LIM] ($rose(bus_data_pin_oe) && bus_clock_pin_i);
  endproperty
  property p_stop;
    done |-> !bus_data_pin_oe && !bus_clock_pin_oe && bus_data_pin_i;
  endproperty
  property p_done;
    done |=> !done && cmd_ready;
  endproperty
  property p_idle;
    cmd_ready |-> !bus_clock_pin_oe && !bus_data_pin_oe;
  endproperty
  property p_err;
    $rose(busy) |-> ##[0:1] (!nack_err && !pec_err);
  endproperty
  property p_rx;
    rx_valid |-> busy ##1 !rx_valid;
  endproperty
  a_clk_od: assert property (p_clk_od) else $error("clock line driven high");
  a_dat_od: assert property (p_dat_od) else $error("data line driven high");
  a_take: assert property (p_take) else $error("request not taken");
  a_start: assert property (p_start) else $error("no start condition");
  a_stop: assert property (p_stop) else $error("done without stop");
  a_done: assert property (p_done) else $error("done not a pulse");
  a_idle: assert property (p_idle) else $error("lines held while idle");
  a_err: assert property (p_err) else $error("errors not cleared");
  a_rx: assert property (p_rx) else $error("bad block byte pulse");
endmodule
bind smh_host smh_host_asserts #(.QUARTER(QUARTER)) u_smh_host_asserts (
  .clk(clk),
  .rst(rst),
  .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready),
  .busy(busy),
  .done(done),
  .nack_err(nack_err),
  .pec_err(pec_err),
  .rx_valid(rx_valid),
  .bus_clock_pin_i(bus_clock_pin_i),
  .bus_clock_pin_o(bus_clock_pin_o),
  .bus_clock_pin_oe(bus_clock_pin_oe),
  .bus_data_pin_i(bus_data_pin_i),
  .bus_data_pin_o(bus_data_pin_o),
  .bus_data_pin_oe(bus_data_pin_oe)
);
`default_nettype wire

/* smh_dev.sv */
// Behavioural gauge slave answering the host on the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
module smh_dev (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  logic [15:0] mem [0:255];
  logic [7:0] first;
  logic slow;
  logic corrupt;
  int bad_codes;
  // One packet code step over a whole byte.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    end
    return r;
  endfunction
  // Samples a bit; cond is 1 for a start, 2 for a stop seen with clock high.
  task automatic rx_bit(output logic v, output int cond);
    @(posedge scl);
    v = sda;
    wait (!scl || sda !== v);
    // The host may move data in the very step its clock falls, so let both lines settle.
    #1;
    cond = scl ? (sda ? 2 : 1) : 0;
  endtask
  // Receives a byte, giving up on a start or stop.
  task automatic rx_byte(output logic [7:0] b, output int cond);
    logic v;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rx_bit(v, cond);
      if (cond != 0) return;
      b = {b[6:0], v};
    end
  endtask
  // Pulls data low for the acknowledge bit, then may stretch the clock.
  task automatic ack(input logic ok);
    if (ok) begin
      sda_oe = 1'b1;
      @(negedge scl);
      sda_oe = 1'b0;
      if (slow) begin
        scl_oe = 1'b1;
        #300 scl_oe = 1'b0;
      end
    end
  endtask
  // Sends a byte by releasing or pulling data; a is the master's acknowledge.
  task automatic tx_byte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = !b[i];
      @(negedge scl);
    end
    sda_oe = 1'b0;
    @(posedge scl);
    a = !sda;
    if (a) @(negedge scl);
  endtask
  // Transaction engine for read word, write word and block read.
  initial begin
    logic [7:0] b, code, crc;
    logic [7:0] q[$];
    logic a;
    int c;
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    slow = 1'b0;
    corrupt = 1'b0;
    bad_codes = 0;
    mem[8'h0f] = 16'h03e9;
    forever begin
      @(negedge sda iff scl);
      // A data fall in the same step as a clock fall is no start; wait for the lines to settle.
      #1;
      if (!scl) continue;
      rx_byte(b, c);
      if (c == 0 && b[7:1] == 7'h0b) begin
        first = b;
        ack(1'b1);
        crc = crc8(8'h00, b);
        rx_byte(code, c);
        ack(1'b1);
        crc = crc8(crc, code);
        rx_byte(b, c);
        if (c == 1) begin
          rx_byte(b, c);
          ack(1'b1);
          crc = crc8(crc, b);
          if (code[7:4] == 4'h3) q = '{8'h03, code, code + 8'h01, code + 8'h02};
          else q = '{mem[code][7:0], mem[code][15:8]};
          a = 1'b1;
          foreach (q[i]) begin
            if (a) tx_byte(q[i], a);
            crc = crc8(crc, q[i]);
          end
          if (a) tx_byte(corrupt ? ~crc : crc, a);
        end else if (c == 0) begin
          ack(1'b1);
          crc = crc8(crc, b);
          mem[code][7:0] = b;
          rx_byte(b, c);
          ack(1'b1);
          crc = crc8(crc, b);
          mem[code][15:8] = b;
          rx_byte(b, c);
          if (c == 0) begin
            if (b !== crc) bad_codes++;
            ack(b === crc);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* smh_host_tb.sv */
// Self-checking bench: host controller against a behavioural gauge.
`timescale 1ns/1ps
`default_nettype none
module smh_host_tb;
  import smh_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  smh_kind_t cmd_kind = SMH_READ_WORD;
  logic [6:0] cmd_addr = 7'h0b;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_pec_en = 1'b0;
  logic cmd_ready, busy, done, nack_err, pec_err, rx_valid;
  logic [15:0] rdata;
  logic [7:0] rx_byte;
  logic h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, d_scl_oe, d_sda_oe;
  wire logic scl = !(h_scl_oe || d_scl_oe);
  wire logic sda = !(h_sda_oe || d_sda_oe);
  logic [7:0] rxq[$];
  int n_fail = 0;
  int total_checks = 0;
  smh_host #(.QUARTER(4)) u_smh_host (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_pec_en(cmd_pec_en), .busy(busy), .done(done),
    .nack_err(nack_err), .pec_err(pec_err), .rdata(rdata), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .bus_clock_pin_i(scl), .bus_clock_pin_o(h_scl_o),
    .bus_clock_pin_oe(h_scl_oe), .bus_data_pin_i(sda), .bus_data_pin_o(h_sda_o),
    .bus_data_pin_oe(h_sda_oe));
  smh_dev u_smh_dev (.scl(scl), .sda(sda), .scl_oe(d_scl_oe), .sda_oe(d_sda_oe));
  // Clock and block byte capture.
  always #2.5 clk = ~clk;
  always @(posedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_byte);
  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Presents one request until taken, then waits for its done pulse.
  task automatic run(input smh_kind_t k, input logic [6:0] a, input logic [7:0] c,
      input logic [15:0] w, input logic p);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_code <= c;
    cmd_wdata <= w;
    cmd_pec_en <= p;
    for (int i = 0; i < 99 && busy !== 1'b1; i++) @(posedge clk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 9999 && done !== 1'b1; i++) @(posedge clk);
    check(done, 1'b1);
  endtask
  // Write word with a packet code lands in the gauge.
  task automatic t_write;
    run(SMH_WRITE_WORD, 7'h0b, 8'h20, 16'h1234, 1'b1);
    check(nack_err, 1'b0);
    check(u_smh_dev.mem[8'h20], 16'h1234);
    check(u_smh_dev.first, 8'h16);
    check(16'(u_smh_dev.bad_codes), 16'h0000);
  endtask
  // Read word of the worked example with its packet code.
  task automatic t_known;
    logic [7:0] c;
    logic [7:0] v [5] = '{8'h16, 8'h0f, 8'h17, 8'he9, 8'h03};
    c = 8'h00;
    foreach (v[i]) c = u_smh_dev.crc8(c, v[i]);
    check(c, 8'he8);
    run(SMH_READ_WORD, 7'h0b, 8'h0f, 16'h0000, 1'b1);
    check(rdata, 16'h03e9);
    check(pec_err, 1'b0);
  endtask
  // Back-to-back write and read without codes against a stretching gauge.
  task automatic t_nopec;
    u_smh_dev.slow = 1'b1;
    run(SMH_WRITE_WORD, 7'h0b, 8'h21, 16'ha55a, 1'b0);
    run(SMH_READ_WORD, 7'h0b, 8'h21, 16'h0000, 1'b0);
    check(rdata, 16'ha55a);
    check(nack_err, 1'b0);
    u_smh_dev.slow = 1'b0;
  endtask
  // Block read returns the count's worth of bytes.
  task automatic t_block;
    rxq.delete();
    run(SMH_BLOCK_READ, 7'h0b, 8'h30, 16'h0000, 1'b1);
    check(16'(rxq.size()), 16'h0003);
    for (int i = 0; i < 3 && i < rxq.size(); i++) check(rxq[i], 8'h30 + 8'(i));
    check(pec_err, 1'b0);
  endtask
  // A corrupted gauge code, then an absent address.
  task automatic t_faults;
    u_smh_dev.corrupt = 1'b1;
    run(SMH_READ_WORD, 7'h0b, 8'h0f, 16'h0000, 1'b1);
    check(pec_err, 1'b1);
    u_smh_dev.corrupt = 1'b0;
    run(SMH_READ_WORD, 7'h0c, 8'h0f, 16'h0000, 1'b0);
    check(nack_err, 1'b1);
    check(pec_err, 1'b0);
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_write();
    t_known();
    t_nopec();
    t_block();
    t_faults();
    complete_run();
  end
  // Watchdog against a hang.
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
